//--- hdl/p6g_port6.sv
/*
 * Port 6: eight bidirectional pins with per-bit direction, shared with
 * analog converter inputs and digital peripheral inputs, behind AXI4-Lite.
 * Assumes one clock, a synchronous active-low reset, and a converter that
 * reads analogSel and honours the analog-disable output.
 */
`timescale 1ns/10ps

`include "p6g_defs.svh"

// How it works
// - Eight pins, each direction set separately.
// - Reset clears latch, direction; sets analog-disable.
// - Sampled pin inputs read zero during reset.
// - Direction one means output, nothing else matters.
// - Disabled converter, both zero: input fixed zero.
// - Analog-mode bits read back as zero.
// - Non-analog pins not fixed zero stay ordinary digital bits.
// - Output latch holds; inputs sampled at read.
module p6g_port6 #(
	parameter int PORT_W = 8
) (
	// Clock, reset and freeze
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Register bus
	input wire p6g_pkg::p6g_axi_req_t axiReq,
	output p6g_pkg::p6g_axi_rsp_t axiRsp,
	// Pins
	input wire logic [7:0] pinIn,
	output logic [7:0] pinOut,
	output logic [7:0] pinOe_n,
	// Converter side
	output logic analogDisable,
	output logic [7:0] analogSel,
	// Peripheral inputs (interrupt, counters, key wake)
	output logic [7:0] periphIn
);
	import p6g_pkg::*;

	// ****************************************
	// Elaboration check
	// ****************************************
	generate
		if (PORT_W != 8)
		begin : g_badWidth
			$error("p6g_port6 serves exactly eight pins");
		end
	endgenerate

	// ****************************************
	// State
	// ****************************************
	p6g_state_t s;
	p6g_state_t next_s;

	p6g_mode_t pinMode [8];
	logic [7:0] portRead;
	logic [7:0] analogNow;
	logic [7:0] periphNow;

	// ****************************************
	// Per-pin mode decode
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_pin
			// Direction wins over latch and flag
			assign pinMode[i] = s.dir[i] ? P6G_OUTPUT :
				s.latch[i] ? P6G_INPUT :
				s.adFlag ? P6G_FIXED0 :
				P6G_ANALOG;
			// Output bits read the latch, inputs the synchronised pin
			assign portRead[i] = (pinMode[i] == P6G_OUTPUT) ? s.latch[i] :
				(pinMode[i] == P6G_INPUT) ? s.sync2[i] :
				1'b0;
			assign analogNow[i] = (pinMode[i] == P6G_ANALOG);
			// Peripherals only see pins in digital input mode
			assign periphNow[i] = (pinMode[i] == P6G_INPUT) ? s.sync2[i] : 1'b0;
		end
	endgenerate

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		next_s = s;

		// Two-flop synchroniser; stage one feeds stage two only
		next_s.sync1 = pinIn;
		next_s.sync2 = s.sync1;

		// Write address and data, taken in either order
		if (axiReq.awvalid && s.bus.awready)
		begin
			next_s.awHave = 1'b1;
			next_s.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && s.bus.wready)
		begin
			next_s.wHave = 1'b1;
			next_s.wData = axiReq.wdata[7:0];
			next_s.wLane0 = axiReq.wstrb[0];
		end
		if (s.bus.bvalid && axiReq.bready)
		begin
			next_s.bus.bvalid = 1'b0;
		end

		// Perform the write once both halves are held
		if (s.awHave && s.wHave && !s.bus.bvalid)
		begin
			next_s.awHave = 1'b0;
			next_s.wHave = 1'b0;
			next_s.bus.bvalid = 1'b1;
			next_s.bus.bresp = `P6G_RESP_OKAY;
			case (s.awAddr[7:2])
				`P6G_IDX_LATCH:
				begin
					// Whole byte is stored; a write-back of a read would rewrite modes
					if (s.wLane0)
					begin
						next_s.latch = s.wData;
					end
				end
				`P6G_IDX_DIR:
				begin
					if (s.wLane0)
					begin
						next_s.dir = s.wData;
					end
				end
				`P6G_IDX_CONV:
				begin
					if (s.wLane0)
					begin
						next_s.adFlag = s.wData[`P6G_CONV_ADFLAG_BIT];
					end
				end
				default:
				begin
					next_s.bus.bresp = `P6G_RESP_SLVERR;
				end
			endcase
		end

		// Hold new write halves off while one is pending or answered
		next_s.bus.awready = !next_s.awHave && !next_s.bus.bvalid;
		next_s.bus.wready = !next_s.wHave && !next_s.bus.bvalid;

		// Read channel
		if (s.bus.rvalid && axiReq.rready)
		begin
			next_s.bus.rvalid = 1'b0;
		end
		if (axiReq.arvalid && s.bus.arready)
		begin
			next_s.bus.rvalid = 1'b1;
			next_s.bus.rresp = `P6G_RESP_OKAY;
			next_s.bus.rdata = 32'h00000000;
			case (axiReq.araddr[7:2])
				`P6G_IDX_LATCH:
				begin
					// Inputs are sampled at the moment of the read
					next_s.bus.rdata = {24'h000000, portRead};
				end
				`P6G_IDX_DIR:
				begin
					next_s.bus.rdata = {24'h000000, s.dir};
				end
				`P6G_IDX_CONV:
				begin
					next_s.bus.rdata = {31'h00000000, s.adFlag};
				end
				default:
				begin
					next_s.bus.rresp = `P6G_RESP_SLVERR;
				end
			endcase
		end
		next_s.bus.arready = !next_s.bus.rvalid;

		// Pin and side outputs, registered so every output is a flop
		next_s.pinOut = s.latch;
		next_s.pinOe_n = ~s.dir;
		next_s.analogSel = analogNow;
		next_s.periphIn = periphNow;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.latch <= `P6G_RST_LATCH;
			s.dir <= `P6G_RST_DIR;
			s.adFlag <= `P6G_RST_ADFLAG;
			// Sampled inputs held at zero while reset lasts
			s.sync1 <= 8'h00;
			s.sync2 <= 8'h00;
			s.pinOe_n <= 8'hff;
		end
		else if (clkEn)
		begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign axiRsp = s.bus;
	assign pinOut = s.pinOut;
	assign pinOe_n = s.pinOe_n;
	assign analogDisable = s.adFlag;
	assign analogSel = s.analogSel;
	assign periphIn = s.periphIn;

endmodule : p6g_port6

//--- shared/p6g_defs.svh
/*
 * Offsets, field positions, reset values and response codes of the port 6 block.
 * Assumes inclusion by bare name from the design and the bench.
 */
`ifndef P6G_DEFS_SVH
`define P6G_DEFS_SVH

// ****************************************
// Register indexes (byte address is four times the index)
// ****************************************
`define P6G_IDX_LATCH 6'h06
`define P6G_IDX_DIR 6'h0c
`define P6G_IDX_CONV 6'h0e

// ****************************************
// Field positions
// ****************************************
`define P6G_CONV_ADFLAG_BIT 0

// ****************************************
// Reset values
// ****************************************
`define P6G_RST_LATCH 8'h00
`define P6G_RST_DIR 8'h00
`define P6G_RST_ADFLAG 1'b1

// ****************************************
// AXI4-Lite response codes
// ****************************************
`define P6G_RESP_OKAY 2'h0
`define P6G_RESP_SLVERR 2'h2

`endif

//--- shared/p6g_pkg.sv
/*
 * Types of the port 6 block: bus carriers, pin modes and the block state.
 * Assumes an AXI4-Lite master with 8-bit addresses and 32-bit data.
 */
package p6g_pkg;

	// ****************************************
	// Bus carriers
	// ****************************************
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} p6g_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} p6g_axi_rsp_t;

	// ****************************************
	// Pin modes
	// ****************************************
	typedef enum logic [1:0] {
		P6G_FIXED0,
		P6G_INPUT,
		P6G_ANALOG,
		P6G_OUTPUT
	} p6g_mode_t;

	// ****************************************
	// Whole block state
	// ****************************************
	typedef struct packed {
		p6g_axi_rsp_t bus;
		logic awHave;
		logic [7:0] awAddr;
		logic wHave;
		logic [7:0] wData;
		logic wLane0;
		logic [7:0] latch;
		logic [7:0] dir;
		logic adFlag;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] pinOut;
		logic [7:0] pinOe_n;
		logic [7:0] analogSel;
		logic [7:0] periphIn;
	} p6g_state_t;

endpackage : p6g_pkg

//--- tb/p6g_pin_model.sv
/* Pin model: the board seen from the port 6 pins.
   Assumes the bench supplies the level that the board puts on undriven pins. */
`timescale 1ns/10ps
module p6g_pin_model (
	// Port side
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe_n,
	// Board side
	input wire logic [7:0] extLevel,
	output logic [7:0] pinIn
);
	// Driven bits show the port, the rest the board
	assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & extLevel);
endmodule : p6g_pin_model

//--- tb/p6g_port6_chk.sv
/* Checker on the ports of p6g_port6.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/10ps
module p6g_port6_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// Bus and pins
	input wire p6g_pkg::p6g_axi_req_t axiReq,
	input wire p6g_pkg::p6g_axi_rsp_t axiRsp,
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe_n,
	input wire logic analogDisable,
	input wire logic [7:0] analogSel,
	input wire logic [7:0] periphIn
);
	import p6g_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	chk_reset_outs: assert property (disable iff (1'b0) !rst_n |=> !pinOut && &pinOe_n && analogDisable)
		else $error("outputs wrong after reset");
	chk_reset_inputs: assert property (disable iff (1'b0) !rst_n |=> !periphIn && !analogSel)
		else $error("inputs not forced low");
	chk_output_only: assert property (!(~pinOe_n & (analogSel | periphIn)))
		else $error("output pin used as input");
	// Pin selects follow the flag one cycle late, so a fresh disable is given that cycle
	chk_flag_blocks: assert property (analogDisable && $past(analogDisable) |-> !analogSel)
		else $error("analog select while disabled");
	chk_analog_latch: assert property (!(analogSel & pinOut))
		else $error("analog pin with latch set");
	chk_digital_in: assert property (!(periphIn & ~pinOut))
		else $error("input passed with latch clear");
	chk_latch_hold: assert property (!axiRsp.bvalid |=> $stable(pinOut) && $stable(pinOe_n))
		else $error("pins changed without a write");
	chk_read_answer: assert property (clkEn && axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
		else $error("read not answered");
	chk_read_stands: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
		else $error("read data dropped");
endmodule : p6g_port6_chk
bind p6g_port6 p6g_port6_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .axiReq(axiReq),
	.axiRsp(axiRsp), .pinOut(pinOut), .pinOe_n(pinOe_n), .analogDisable(analogDisable),
	.analogSel(analogSel), .periphIn(periphIn));

//--- tb/p6g_port6_tb.sv
/* Bench for p6g_port6 over AXI4-Lite, pins through the pin model.
   Assumes the checker binds itself. */
`timescale 1ns/10ps
`include "p6g_defs.svh"
module p6g_port6_tb;
	import p6g_pkg::*;
	localparam logic [7:0] aLatch = {`P6G_IDX_LATCH, 2'b00};
	localparam logic [7:0] aDir = {`P6G_IDX_DIR, 2'b00};
	localparam logic [7:0] aConv = {`P6G_IDX_CONV, 2'b00};
	logic ref_clk = 0;
	logic rst_n = 0;
	logic clkEn = 1;
	logic [7:0] extLevel = 8'h5a;
	p6g_axi_req_t axiReq = '0;
	p6g_axi_rsp_t axiRsp;
	logic [7:0] pinIn, pinOut, pinOe_n, analogSel, periphIn;
	logic analogDisable;
	logic [31:0] d;
	logic [1:0] r;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	p6g_port6 uut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .axiReq(axiReq), .axiRsp(axiRsp),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n), .analogDisable(analogDisable),
		.analogSel(analogSel), .periphIn(periphIn));
	p6g_pin_model pins (.pinOut(pinOut), .pinOe_n(pinOe_n), .extLevel(extLevel), .pinIn(pinIn));
	initial
	begin
		forever #2 ref_clk = ~ref_clk;
	end
	// A hung handshake ends the run here
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			failures++;
			report_and_stop();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic aw;
		logic w;
		@(posedge ref_clk);
		aw = 1;
		w = 1;
		axiReq.awaddr <= a;
		axiReq.wdata <= {24'h0, v};
		axiReq.wstrb <= 4'hf;
		axiReq.awvalid <= 1;
		axiReq.wvalid <= 1;
		axiReq.bready <= 1;
		while (aw || w)
		begin
			@(posedge ref_clk);
			aw = aw && !axiRsp.awready;
			w = w && !axiRsp.wready;
			axiReq.awvalid <= aw;
			axiReq.wvalid <= w;
		end
		while (!axiRsp.bvalid)
			@(posedge ref_clk);
		r = axiRsp.bresp;
		axiReq.bready <= 0;
	endtask : wr
	// Ready comes a cycle late so that the answer must stand
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		axiReq.araddr <= a;
		axiReq.arvalid <= 1;
		do
			@(posedge ref_clk);
		while (!axiRsp.arready);
		axiReq.arvalid <= 0;
		@(posedge ref_clk);
		axiReq.rready <= 1;
		do
			@(posedge ref_clk);
		while (!axiRsp.rvalid);
		d = axiRsp.rdata;
		r = axiRsp.rresp;
		axiReq.rready <= 0;
	endtask : rd
	task automatic reset_values;
		rd(aLatch);
		check("latch", d, 32'h0);
		rd(aDir);
		check("dir", d, 32'h0);
		rd(aConv);
		check("conv", d, 32'h1);
		check("analogDisable", analogDisable, 32'h1);
	endtask : reset_values
	task automatic mixed_port;
		wr(aDir, 8'h0f);
		wr(aLatch, 8'h3c);
		repeat (4) @(posedge ref_clk);
		check("pinOe_n", pinOe_n, 8'hf0);
		check("pinOut", pinOut, 8'h3c);
		check("periphIn", periphIn, 8'h30 & extLevel);
		rd(aLatch);
		check("read", d, 8'h0c | (8'h30 & extLevel));
	endtask : mixed_port
	task automatic analog_mode;
		wr(aConv, 8'h00);
		extLevel <= 8'ha5;
		repeat (4) @(posedge ref_clk);
		check("analogSel", analogSel, 8'hc0);
		check("periphIn", periphIn, 8'h20);
		rd(aLatch);
		check("read", d, 8'h2c);
		check("analogDisable", analogDisable, 32'h0);
		// A low clock enable must hold the sampled pins
		clkEn <= 0;
		extLevel <= 8'h5a;
		repeat (4) @(posedge ref_clk);
		check("frozen periphIn", periphIn, 8'h20);
		clkEn <= 1;
		repeat (4) @(posedge ref_clk);
		check("periphIn", periphIn, 8'h10);
	endtask : analog_mode
	task automatic all_output;
		// Converter off first: no analog pin may become an output
		wr(aConv, 8'h01);
		wr(aLatch, 8'ha5);
		wr(aDir, 8'hff);
		repeat (2) @(posedge ref_clk);
		check("pins", {pinOut, pinOe_n, analogSel, periphIn}, 32'ha5000000);
		rd(aLatch);
		check("read", d, 8'ha5);
	endtask : all_output
	task automatic unmapped;
		wr(8'hfc, 8'h55);
		check("bresp", r, `P6G_RESP_SLVERR);
		rd(8'hfc);
		check("rresp", r, `P6G_RESP_SLVERR);
		check("rdata", d, 32'h0);
	endtask : unmapped
	task automatic report_and_stop;
		$display("checks %0d, failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (10) @(posedge ref_clk);
		check("periphIn", periphIn, 8'h00);
		rst_n <= 1;
		reset_values();
		mixed_port();
		analog_mode();
		all_output();
		unmapped();
		report_and_stop();
	end
endmodule : p6g_port6_tb
